// [common/ddr_link_if.sv]
// Purpose: Pins between the two ends.
// Assumes: The controller drives ck and rst.
// Notes:   No high impedance; an idle data bus reads zero.
`timescale 1ns/10ps
interface ddr_link_if;
  import ddr_link_pkg::*;
  logic                ck;
  logic                rst;
  cmd_type             cmd;
  logic [BANK_W-1:0]   bank;
  logic [ADDR_W-1:0]   addr;
  logic [DQ_W-1:0]     dq_c;
  logic                dq_c_oe;
  logic [DQ_W-1:0]     dq_d;
  logic                dq_d_oe;
  logic [LANES-1:0]    dm_n;
  logic [DQ_W-1:0]     dq;

  // Wire level of the shared data bus
  assign dq = dq_d_oe ? dq_d : (dq_c_oe ? dq_c : 16'h0000);

  modport ctrl (output ck, rst, cmd, bank, addr, dq_c, dq_c_oe, dm_n,
                input dq_d_oe, dq);
  modport dev  (input ck, rst, cmd, bank, addr, dm_n, dq, dq_c_oe,
                output dq_d, dq_d_oe);
endinterface

// [common/ddr_link_pkg.sv]
// Purpose: Constants and types shared by both link ends.
// Assumes: One beat per link clock, made by the controller.
// Notes:   Mode fields ride on the address bus.
// How it works
// R1: Chop to four beats: fixed chop, or on-the-fly with A12 low
// R2: Eight beats: fixed eight, or on-the-fly with A12 high
// R3: Two-clock preamble forces write latency above minimum
// R4: Precharge waits additive latency plus read-to-precharge
// R5: Precharge also waits activate-to-precharge minimum
// R6: Activate waits precharge time and row cycle
// R7: One mask input per eight data bits
// R8: Mask sampled with the same timing as data
// R9: Mask ignored on reads; inversion flag when enabled
// R10: Strobe-to-clock skew kept on every burst edge
// R11: Every data edge of a burst meets timing
// R12: Recovery counted from edge after last beat
// R13: Read with A10 high precharges after burst
// R14: Latencies are additive plus CAS or write CAS
package ddr_link_pkg;

  typedef enum logic [2:0] {CMD_NOP, CMD_MRS, CMD_ACT, CMD_PRE, CMD_RD, CMD_WR} cmd_type;

  localparam int NUM_BANKS = 8;
  localparam int BANK_W    = 3;
  localparam int ADDR_W    = 13;
  localparam int DQ_W      = 16;
  localparam int LANES     = DQ_W / 8;
  localparam int MAX_BEATS = 8;

  // Address bit positions
  localparam int A10_POS = 10;
  localparam int A11_POS = 11;
  localparam int A12_POS = 12;

  // Mode register select and field positions
  localparam logic [BANK_W-1:0] MR0_SEL = 3'h0;
  localparam logic [BANK_W-1:0] MR1_SEL = 3'h1;
  localparam logic [BANK_W-1:0] MR2_SEL = 3'h2;
  localparam logic [BANK_W-1:0] MR5_SEL = 3'h5;
  localparam int MR0_CL_LSB  = 2;
  localparam int MR2_PRE_POS = 4;

  // Burst field encodings
  localparam logic [1:0] BURST_FIXED8 = 2'h0;
  localparam logic [1:0] BURST_OTF    = 2'h1;
  localparam logic [1:0] BURST_CHOP4  = 2'h2;

  // Values after reset, and the write latency floor
  localparam logic [1:0] BURST_RST = 2'h0;
  localparam logic [3:0] CL_RST    = 4'hB;
  localparam logic [3:0] AL_RST    = 4'h0;
  localparam logic [3:0] CWL_RST   = 4'h9;
  localparam logic [3:0] CWL_MIN   = 4'h9;

  // Link clock: four system clocks each
  localparam int CLK_NS   = 50;
  localparam int CK_DIV   = 4;
  localparam logic [1:0] LAUNCH_PH = 2'h3;
  localparam logic [1:0] CAP_PH    = 2'h1;

  // Array timings in ns, counts in link clocks (rounded up)
  localparam int T_RAS_NS = 32;
  localparam int T_RP_NS  = 14;
  localparam int T_RC_NS  = 46;
  localparam int T_RTP_NS = 8;
  localparam int T_WR_NS  = 15;
  localparam int T_WTR_NS = 8;
  localparam int CK_NS    = CLK_NS * CK_DIV;
  localparam logic [5:0] RAS_CK = 6'((T_RAS_NS + CK_NS - 1) / CK_NS);
  localparam logic [5:0] RP_CK  = 6'((T_RP_NS + CK_NS - 1) / CK_NS);
  localparam logic [5:0] RC_CK  = 6'((T_RC_NS + CK_NS - 1) / CK_NS);
  localparam logic [5:0] RTP_CK = 6'((T_RTP_NS + CK_NS - 1) / CK_NS);
  localparam logic [5:0] WR_CK  = 6'((T_WR_NS + CK_NS - 1) / CK_NS);
  localparam logic [5:0] WTR_CK = 6'((T_WTR_NS + CK_NS - 1) / CK_NS);

  // Burst length decode shared by both ends
  function automatic logic burst_is8(input logic [1:0] mode, input logic a12);
    return (mode == BURST_FIXED8) || ((mode == BURST_OTF) && a12); // R1 R2
  endfunction

endpackage

// [design/bit_sync.sv]
// Purpose: Two-flop synchroniser.
// Assumes: Grouped bits are read only once stable.
// Notes:   First stage feeds only the second.
`timescale 1ns/10ps
module bit_sync #(parameter int WIDTH = 1) (
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_d,
  output logic      [WIDTH-1:0] o_q
);
  logic [WIDTH-1:0] meta_reg;

  // Two stages against metastability
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      meta_reg <= '0;
      o_q      <= '0;
    end else begin
      meta_reg <= i_d;
      o_q      <= meta_reg;
    end
  end
endmodule

// [design/ddr_ctrl_end.sv]
// Purpose: Controller end: link clock, commands, bursts.
// Assumes: One request in flight; rows already open.
// Notes:   Requests taken only in the launch phase.
`timescale 1ns/10ps
module ddr_ctrl_end
  import ddr_link_pkg::*;
(
  input  wire logic                     i_clock,
  input  wire logic                     i_rst,
  input  wire logic                     i_req_valid,
  input  wire cmd_type                  i_req_cmd,
  input  wire logic [BANK_W-1:0]        i_req_bank,
  input  wire logic [ADDR_W-1:0]        i_req_addr,
  input  wire logic [MAX_BEATS*DQ_W-1:0] i_wr_data,
  input  wire logic [MAX_BEATS*LANES-1:0] i_wr_mask_n,
  output logic                          o_req_ready,
  output logic [MAX_BEATS*DQ_W-1:0]     o_rd_data,
  output logic                          o_rd_valid,
  ddr_link_if.ctrl                      lnk
);
  typedef enum {ST_IDLE, ST_RD, ST_WR} state_type;

  state_type             state_reg;
  logic [1:0]            ph_reg;
  logic                  rst_reg;
  cmd_type               cmd_reg;
  logic [BANK_W-1:0]     bank_reg;
  logic [ADDR_W-1:0]     addr_reg;
  logic [DQ_W-1:0]       dq_reg;
  logic                  dq_oe_reg;
  logic [LANES-1:0]      dm_reg;
  logic [1:0]            burst_reg;
  logic [3:0]            al_reg, cwl_reg;
  logic                  bl8_reg, ap_reg, ap_pend_reg;
  logic [5:0]            op_reg, wtr_reg;
  logic [3:0]            beat_reg;
  logic [MAX_BEATS*DQ_W-1:0]  wdata_reg;
  logic [MAX_BEATS*LANES-1:0] wmask_reg;
  logic                  launch, accept, gate, wr_done;
  logic [5:0]            op_nx, wl, bl;
  logic [2:0]            widx;
  logic [3:0]            cwl_set;
  logic [NUM_BANKS-1:0]  act_ok, pre_ok;
  logic [DQ_W:0]         rx_q;

  assign launch  = (ph_reg == LAUNCH_PH);
  assign op_nx   = op_reg + 6'h01;
  assign wl      = 6'(al_reg) + 6'(cwl_reg); // R14
  assign bl      = bl8_reg ? 6'h08 : 6'h04;
  assign widx    = 3'(op_nx - wl);
  assign wr_done = launch && (state_reg == ST_WR) && (op_nx == wl + bl);

  ////////////////////////////////////////////////////////////////////////////
  // Link clock from a divider; high in the upper half of the phase count
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ph_reg <= 2'h0;
    end else begin
      ph_reg <= ph_reg + 2'h1;
    end
  end
  assign lnk.ck = ph_reg[1];

  // Link reset stretched to the next launch so the device sees a rise in it
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rst_reg <= 1'b1;
    end else if (launch) begin
      rst_reg <= 1'b0;
    end
  end
  assign lnk.rst = rst_reg;

  // Read data and enable cross from the link clock
  bit_sync #(.WIDTH(DQ_W + 1)) u_rx_sync (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_d     ({lnk.dq_d_oe, lnk.dq}),
    .o_q     (rx_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Request gate: bank timing met before activate or precharge, write-to-read spacing before a read
  always_comb begin
    case (i_req_cmd)
      CMD_ACT: gate = act_ok[i_req_bank]; // R6
      CMD_PRE: gate = pre_ok[i_req_bank]; // R4 R5
      CMD_RD:  gate = (wtr_reg == 6'h00); // R12
      default: gate = 1'b1;
    endcase
  end
  assign o_req_ready = (state_reg == ST_IDLE) && launch && !ap_pend_reg && gate;
  assign accept      = o_req_ready && i_req_valid;

  // Long preamble raises write latency off the floor
  always_comb begin
    cwl_set = i_req_addr[3:0];
    if (i_req_addr[MR2_PRE_POS] && (cwl_set < CWL_MIN + 4'h1)) begin
      cwl_set = CWL_MIN + 4'h1; // R3
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-bank timers, counted in link clocks at each launch
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    logic [5:0] since_act_reg, since_pre_reg, hold_reg;
    logic       act_ev, pre_ev, rd_ev;
    assign act_ev = accept && (i_req_cmd == CMD_ACT) && (i_req_bank == b);
    assign rd_ev  = accept && (i_req_cmd == CMD_RD) && (i_req_bank == b);
    assign pre_ev = (accept && (i_req_cmd == CMD_PRE) && (i_req_bank == b)) ||
                    (launch && ap_pend_reg && (bank_reg == b));
    always_ff @(posedge i_clock) begin
      if (i_rst) begin
        since_act_reg <= 6'h3F;
        since_pre_reg <= 6'h3F;
        hold_reg      <= 6'h00;
      end else if (launch) begin
        if (act_ev) begin
          since_act_reg <= 6'h00;
        end else if (since_act_reg != 6'h3F) begin
          since_act_reg <= since_act_reg + 6'h01;
        end
        if (pre_ev) begin
          since_pre_reg <= 6'h00;
        end else if (since_pre_reg != 6'h3F) begin
          since_pre_reg <= since_pre_reg + 6'h01;
        end
        if (rd_ev) begin
          hold_reg <= 6'(al_reg) + RTP_CK; // R4
        end else if (wr_done && (bank_reg == b)) begin
          hold_reg <= WR_CK; // R12
        end else if (hold_reg != 6'h00) begin
          hold_reg <= hold_reg - 6'h01;
        end
      end
    end
    assign act_ok[b] = (since_pre_reg >= RP_CK) && (since_act_reg >= RC_CK); // R6
    assign pre_ok[b] = (since_act_reg >= RAS_CK) && (hold_reg == 6'h00); // R4 R5
  end

  // Write-to-read spacing starts at the edge after the last beat
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      wtr_reg <= 6'h00;
    end else if (wr_done) begin
      wtr_reg <= WTR_CK; // R12
    end else if (launch && wtr_reg != 6'h00) begin
      wtr_reg <= wtr_reg - 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command pins: one link clock per command, launched on the falling edge
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cmd_reg  <= CMD_NOP;
      bank_reg <= '0;
      addr_reg <= '0;
    end else if (accept) begin
      cmd_reg  <= i_req_cmd;
      bank_reg <= i_req_bank;
      addr_reg <= i_req_addr;
      if (i_req_cmd == CMD_MRS && i_req_bank == MR2_SEL) begin
        addr_reg[3:0] <= cwl_set; // R3
      end
    end else if (launch) begin
      cmd_reg <= CMD_NOP;
    end
  end
  assign lnk.cmd  = cmd_reg;
  assign lnk.bank = bank_reg;
  assign lnk.addr = addr_reg;

  // Own copy of the burst, additive latency and write latency settings
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      burst_reg <= BURST_RST;
      al_reg    <= AL_RST;
      cwl_reg   <= CWL_RST;
    end else if (accept && i_req_cmd == CMD_MRS) begin
      case (i_req_bank)
        MR0_SEL: burst_reg <= i_req_addr[1:0];
        MR1_SEL: al_reg <= i_req_addr[3:0];
        MR2_SEL: cwl_reg <= cwl_set; // R3
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Burst sequencing for reads and writes
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_reg   <= ST_IDLE;
      op_reg      <= '0;
      beat_reg    <= '0;
      bl8_reg     <= 1'b0;
      ap_reg      <= 1'b0;
      ap_pend_reg <= 1'b0;
      dq_reg      <= '0;
      dq_oe_reg   <= 1'b0;
      dm_reg      <= '1;
      wdata_reg   <= '0;
      wmask_reg   <= '0;
      o_rd_data   <= '0;
      o_rd_valid  <= 1'b0;
    end else begin
      o_rd_valid <= 1'b0;
      if (launch && ap_pend_reg) begin
        ap_pend_reg <= 1'b0;
      end
      case (state_reg)
        ST_IDLE: begin
          if (accept && (i_req_cmd == CMD_RD || i_req_cmd == CMD_WR)) begin
            state_reg <= (i_req_cmd == CMD_RD) ? ST_RD : ST_WR;
            op_reg    <= '0;
            beat_reg  <= '0;
            bl8_reg   <= burst_is8(burst_reg, i_req_addr[A12_POS]); // R1 R2
            ap_reg    <= i_req_addr[A10_POS];
            wdata_reg <= i_wr_data;
            wmask_reg <= i_wr_mask_n;
          end
        end
        ST_WR: begin
          if (launch) begin
            op_reg <= op_nx;
            if (op_nx >= wl && op_nx < wl + bl) begin
              dq_reg    <= wdata_reg[DQ_W*widx +: DQ_W]; // R10 R11
              dm_reg    <= wmask_reg[LANES*widx +: LANES]; // R8
              dq_oe_reg <= 1'b1;
            end else if (wr_done) begin
              dq_oe_reg <= 1'b0;
              dm_reg    <= '1;
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_RD: begin
          if (ph_reg == CAP_PH && rx_q[DQ_W]) begin
            o_rd_data[DQ_W*beat_reg[2:0] +: DQ_W] <= rx_q[DQ_W-1:0];
            beat_reg <= beat_reg + 4'h1;
            if (6'(beat_reg) + 6'h01 == bl) begin
              o_rd_valid  <= 1'b1;
              ap_pend_reg <= ap_reg; // R13
              state_reg   <= ST_IDLE;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
  assign lnk.dq_c    = dq_reg;
  assign lnk.dq_c_oe = dq_oe_reg;
  assign lnk.dm_n    = dm_reg;
endmodule

// [design/ddr_device_end.sv]
// Purpose: Memory end: mode, bank state, bursts.
// Assumes: Sampling on the rising link clock.
// Notes:   One read and one write burst at a time.
`timescale 1ns/10ps
module ddr_device_end
  import ddr_link_pkg::*;
#(parameter int COL_W = 4) (
  ddr_link_if.dev              lnk,
  output logic [NUM_BANKS-1:0] o_bank_open,
  output logic                 o_burst8,
  output logic                 o_dbi_en
);
  localparam int DEPTH = NUM_BANKS << COL_W;

  logic [1:0]  burst_reg;
  logic [3:0]  cl_reg, al_reg, cwl_reg;
  logic        dbi_reg;
  logic [5:0]  rd_wait_reg, wr_wait_reg;
  logic        rd_busy_reg, wr_busy_reg, rd_len8_reg, wr_len8_reg, rd_ap_reg, oe_reg;
  logic [3:0]  rd_beat_reg, wr_beat_reg;
  logic [BANK_W-1:0] rd_bank_reg, wr_bank_reg;
  logic [COL_W-1:0]  rd_col_reg, wr_col_reg;
  logic        rd_fire, wr_fire, rd_end, cmd8;
  logic [BANK_W+COL_W-1:0] rd_addr, wr_addr;

  assign cmd8    = burst_is8(burst_reg, lnk.addr[A12_POS]); // R1 R2
  assign rd_fire = (rd_wait_reg == 6'h01) ||
                   (rd_busy_reg && rd_beat_reg != (rd_len8_reg ? 4'h8 : 4'h4));
  assign rd_end  = rd_busy_reg && !rd_fire;
  assign wr_fire = (wr_wait_reg == 6'h01) ||
                   (wr_busy_reg && wr_beat_reg != (wr_len8_reg ? 4'h8 : 4'h4));
  assign rd_addr = {rd_bank_reg, rd_col_reg + COL_W'(rd_beat_reg)};
  assign wr_addr = {wr_bank_reg, wr_col_reg + COL_W'(wr_beat_reg)};

  ////////////////////////////////////////////////////////////////////////////
  // Mode registers written by a mode command
  always_ff @(posedge lnk.ck) begin
    if (lnk.rst) begin
      burst_reg <= BURST_RST;
      cl_reg    <= CL_RST;
      al_reg    <= AL_RST;
      cwl_reg   <= CWL_RST;
      dbi_reg   <= 1'b0;
    end else if (lnk.cmd == CMD_MRS) begin
      case (lnk.bank)
        MR0_SEL: begin
          burst_reg <= lnk.addr[1:0];
          cl_reg    <= lnk.addr[MR0_CL_LSB +: 4];
        end
        MR1_SEL: al_reg  <= lnk.addr[3:0];
        MR2_SEL: cwl_reg <= lnk.addr[3:0];
        MR5_SEL: dbi_reg <= lnk.addr[A11_POS]; // R9
        default: ;
      endcase
    end
  end

  // Open rows; auto precharge closes the bank once the read burst ends
  always_ff @(posedge lnk.ck) begin
    if (lnk.rst) begin
      o_bank_open <= '0;
    end else begin
      if (rd_end && rd_ap_reg) begin
        o_bank_open[rd_bank_reg] <= 1'b0; // R13
      end
      if (lnk.cmd == CMD_ACT) begin
        o_bank_open[lnk.bank] <= 1'b1;
      end else if (lnk.cmd == CMD_PRE) begin
        o_bank_open[lnk.bank] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read burst: first beat leaves at additive plus CAS latency
  always_ff @(posedge lnk.ck) begin
    if (lnk.rst) begin
      rd_wait_reg <= '0;
      rd_busy_reg <= 1'b0;
      rd_beat_reg <= '0;
      rd_len8_reg <= 1'b0;
      rd_ap_reg   <= 1'b0;
      rd_bank_reg <= '0;
      rd_col_reg  <= '0;
      oe_reg      <= 1'b0;
      o_burst8    <= 1'b0;
    end else begin
      oe_reg <= rd_fire;
      if (lnk.cmd == CMD_RD) begin
        rd_wait_reg <= 6'(al_reg) + 6'(cl_reg); // R14
        rd_busy_reg <= 1'b0;
        rd_beat_reg <= '0;
        rd_len8_reg <= cmd8; // R1 R2
        o_burst8    <= cmd8;
        rd_ap_reg   <= lnk.addr[A10_POS]; // R13
        rd_bank_reg <= lnk.bank;
        rd_col_reg  <= lnk.addr[COL_W-1:0];
      end else begin
        if (rd_wait_reg > 6'h1) begin
          rd_wait_reg <= rd_wait_reg - 6'h01;
        end else if (rd_wait_reg == 6'h01) begin
          rd_wait_reg <= '0;
          rd_busy_reg <= 1'b1;
        end
        if (rd_fire) begin
          rd_beat_reg <= rd_beat_reg + 4'h1;
        end else if (rd_end) begin
          rd_busy_reg <= 1'b0;
        end
      end
    end
  end
  assign lnk.dq_d_oe = oe_reg;

  // Write burst: first beat taken at additive plus write CAS latency
  always_ff @(posedge lnk.ck) begin
    if (lnk.rst) begin
      wr_wait_reg <= '0;
      wr_busy_reg <= 1'b0;
      wr_beat_reg <= '0;
      wr_len8_reg <= 1'b0;
      wr_bank_reg <= '0;
      wr_col_reg  <= '0;
    end else if (lnk.cmd == CMD_WR) begin
      wr_wait_reg <= 6'(al_reg) + 6'(cwl_reg); // R14
      wr_busy_reg <= 1'b0;
      wr_beat_reg <= '0;
      wr_len8_reg <= cmd8; // R1 R2
      wr_bank_reg <= lnk.bank;
      wr_col_reg  <= lnk.addr[COL_W-1:0];
    end else begin
      if (wr_wait_reg > 6'h1) begin
        wr_wait_reg <= wr_wait_reg - 6'h01;
      end else if (wr_wait_reg == 6'h01) begin
        wr_wait_reg <= '0;
        wr_busy_reg <= 1'b1;
      end
      if (wr_fire) begin
        wr_beat_reg <= wr_beat_reg + 4'h1;
      end else if (wr_busy_reg) begin
        wr_busy_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte lanes: each has its own mask pin, sampled on the data edge
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    logic [7:0] mem [0:DEPTH-1];
    logic [7:0] q_reg;
    logic [7:0] din;
    // Inversion mode: a low flag means the byte arrived inverted
    assign din = (dbi_reg && !lnk.dm_n[i]) ? ~lnk.dq[8*i +: 8] : lnk.dq[8*i +: 8];
    always_ff @(posedge lnk.ck) begin
      if (wr_fire && (dbi_reg || lnk.dm_n[i])) begin // R7 R8 R9
        mem[wr_addr] <= din;
      end
      if (rd_fire) begin // R9
        q_reg <= mem[rd_addr];
      end
    end
    assign lnk.dq_d[8*i +: 8] = q_reg;
  end

  assign o_dbi_en = dbi_reg;
endmodule

// [verif/ddr_link_assertions.sv]
// Purpose: Timing checks on the link.
// Assumes: Mode fields mirrored from the wire.
// Notes:   Counts in link clocks, saturating at 63.
`timescale 1ns/10ps
module ddr_link_assertions
  import ddr_link_pkg::*;
(
  input wire logic              ck,
  input wire logic              rst,
  input wire cmd_type           cmd,
  input wire logic [BANK_W-1:0] bank,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic              dq_c_oe,
  input wire logic              dq_d_oe,
  input wire logic [LANES-1:0]  dm_n
);
  logic [1:0]        burst_reg;
  logic [3:0]        cl_reg, al_reg, cwl_reg;
  logic              pre_reg, rd8_reg, wr8_reg, is8;
  logic [5:0]        rdc_reg, wrc_reg, rdb_reg, wrb_reg, wl, rl, wlen;
  logic [BANK_W-1:0] rbank_reg;
  assign is8  = (burst_reg == BURST_FIXED8) || (burst_reg == BURST_OTF && addr[A12_POS]);
  assign wl   = 6'(al_reg) + 6'((pre_reg && cwl_reg < 4'hA) ? 4'hA : cwl_reg);
  assign rl   = 6'(al_reg) + 6'(cl_reg);
  assign wlen = wl + (wr8_reg ? 6'h08 : 6'h04);
  // Saturating, so an old command never wraps into range
  function automatic logic [5:0] inc(input logic [5:0] x);
    return (x == 6'h00 || x == 6'h3F) ? x : x + 6'h01;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // Mode mirror, counters since commands, beats per burst
  always_ff @(posedge ck) begin
    if (rst) begin
      burst_reg <= BURST_RST;
      cl_reg <= CL_RST;
      al_reg <= AL_RST;
      cwl_reg <= CWL_RST;
      pre_reg <= 1'b0;
      rdc_reg <= 6'h00;
      wrc_reg <= 6'h00;
    end else begin
      if (cmd == CMD_MRS && bank == MR0_SEL) begin
        {cl_reg, burst_reg} <= {addr[MR0_CL_LSB +: 4], addr[1:0]};
      end
      if (cmd == CMD_MRS && bank == MR1_SEL) al_reg <= addr[3:0];
      if (cmd == CMD_MRS && bank == MR2_SEL) begin
        {pre_reg, cwl_reg} <= addr[MR2_PRE_POS:0];
      end
      rdc_reg <= (cmd == CMD_RD) ? 6'h01 : inc(rdc_reg);
      wrc_reg <= (cmd == CMD_WR) ? 6'h01 : inc(wrc_reg);
    end
  end
  always_ff @(posedge ck) begin
    rdb_reg <= dq_d_oe ? rdb_reg + 6'h01 : 6'h00;
    wrb_reg <= dq_c_oe ? wrb_reg + 6'h01 : 6'h00;
    if (cmd == CMD_RD) rd8_reg <= is8;
    if (cmd == CMD_RD) rbank_reg <= bank;
    if (cmd == CMD_WR) wr8_reg <= is8;
  end
  ////////////////////////////////////////////////////////////////////////
  sequence s_wr_cmd8;
    cmd == CMD_WR && is8 && wl == 6'h09;
  endsequence
  sequence s_beats8;
    dq_c_oe [*8] ##1 !dq_c_oe;
  endsequence
  a_write_burst_shape: assert property (@(posedge ck) disable iff (rst)
    s_wr_cmd8 |-> ##9 s_beats8) else $error("Write burst shape wrong");
  a_write_start_lat: assert property (@(posedge ck) disable iff (rst)
    $rose(dq_c_oe) |-> wrc_reg == wl) else $error("Write latency wrong");
  a_write_beat_count: assert property (@(posedge ck) disable iff (rst)
    $fell(dq_c_oe) |-> wrb_reg == (wr8_reg ? 6'h08 : 6'h04)) else $error("Write beats wrong");
  a_read_start_lat: assert property (@(posedge ck) disable iff (rst)
    $rose(dq_d_oe) |-> rdc_reg >= rl && rdc_reg <= rl + 6'h01) else $error("Read latency wrong");
  a_read_beat_count: assert property (@(posedge ck) disable iff (rst)
    $fell(dq_d_oe) |-> rdb_reg == (rd8_reg ? 6'h08 : 6'h04)) else $error("Read beats wrong");
  a_mask_idle_high: assert property (@(posedge ck) disable iff (rst)
    !dq_c_oe |-> dm_n == '1) else $error("Mask active outside write");
  a_bus_one_driver: assert property (@(posedge ck) disable iff (rst)
    !(dq_c_oe && dq_d_oe)) else $error("Both ends drive data");
  a_pre_after_read: assert property (@(posedge ck) disable iff (rst)
    cmd == CMD_PRE && bank == rbank_reg && rdc_reg != 6'h00 |-> rdc_reg >= 6'(al_reg) + RTP_CK)
    else $error("Precharge too soon after read");
  a_pre_after_write: assert property (@(posedge ck) disable iff (rst)
    cmd == CMD_PRE && wrc_reg != 6'h00 |-> wrc_reg >= wlen + WR_CK)
    else $error("Precharge inside write recovery");
  a_read_after_write: assert property (@(posedge ck) disable iff (rst)
    cmd == CMD_RD && wrc_reg != 6'h00 |-> wrc_reg >= wlen + WTR_CK)
    else $error("Read inside write to read delay");
endmodule

// [verif/tb_top.sv]
// Purpose: Writes and reads back through both ends.
// Assumes: All traffic on bank 1, column 0.
// Notes:   Controller stretches the short reset to the link.
`timescale 1ns/10ps
module tb_top;
  import ddr_link_pkg::*;
  logic                       i_clock, i_rst, i_req_valid, o_req_ready, o_rd_valid;
  cmd_type                    i_req_cmd;
  logic [BANK_W-1:0]          i_req_bank;
  logic [ADDR_W-1:0]          i_req_addr;
  logic [MAX_BEATS*DQ_W-1:0]  i_wr_data, o_rd_data, shadow;
  logic [MAX_BEATS*LANES-1:0] i_wr_mask_n;
  logic [NUM_BANKS-1:0]       o_bank_open;
  logic                       o_burst8, o_dbi_en;
  int                         error_cnt, total_checks;
  ddr_link_if lnk ();
  ddr_ctrl_end i_ddr_ctrl_end (.i_clock(i_clock), .i_rst(i_rst), .i_req_valid(i_req_valid),
    .i_req_cmd(i_req_cmd), .i_req_bank(i_req_bank), .i_req_addr(i_req_addr),
    .i_wr_data(i_wr_data), .i_wr_mask_n(i_wr_mask_n), .o_req_ready(o_req_ready),
    .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .lnk(lnk.ctrl));
  ddr_device_end i_ddr_device_end (.lnk(lnk.dev), .o_bank_open(o_bank_open),
    .o_burst8(o_burst8), .o_dbi_en(o_dbi_en));
  ddr_link_assertions i_ddr_link_assertions (.ck(lnk.ck), .rst(lnk.rst), .cmd(lnk.cmd),
    .bank(lnk.bank), .addr(lnk.addr), .dq_c_oe(lnk.dq_c_oe), .dq_d_oe(lnk.dq_d_oe),
    .dm_n(lnk.dm_n));
  ////////////////////////////////////////////////////////////////////////
  // Clock; watchdog far past the test length
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  initial begin
    #1000000;
    error_cnt++;
    $display("Error at %0t: watchdog expired", $time);
    give_verdict();
  end
  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (!ok) begin
      error_cnt++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  // Request held until ready is high at a rising edge
  task automatic send(input cmd_type c, input logic [BANK_W-1:0] b, input logic [ADDR_W-1:0] a);
    logic ok;
    i_req_cmd = c;
    i_req_bank = b;
    i_req_addr = a;
    i_req_valid = 1'b1;
    ok = 1'b0;
    for (int n = 0; n < 2000 && !ok; n++) begin
      @(negedge i_clock);
      ok = (o_req_ready === 1'b1);
      @(posedge i_clock);
    end
    #1;
    i_req_valid = 1'b0;
    check(ok, "request never taken");
  endtask
  // Shadow: unmasked bytes, or inverse on a low flag in inversion mode
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [127:0] d,
                    input logic [15:0] m, input int beats, input logic dbi);
    i_wr_data = d;
    i_wr_mask_n = m;
    for (int k = 0; k < beats * LANES; k++) begin
      if (dbi) shadow[8*k +: 8] = m[k] ? d[8*k +: 8] : ~d[8*k +: 8];
      else if (m[k]) shadow[8*k +: 8] = d[8*k +: 8];
    end
    send(CMD_WR, 3'h1, a);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input int beats, input logic exp8);
    logic got;
    send(CMD_RD, 3'h1, a);
    got = 1'b0;
    for (int n = 0; n < 400 && !got; n++) begin
      @(negedge i_clock);
      got = (o_rd_valid === 1'b1);
    end
    check(got, "no read answer");
    check(o_rd_data[63:0] === shadow[63:0], "read beats 0 to 3");
    if (beats == 8) check(o_rd_data[127:64] === shadow[127:64], "read beats 4 to 7");
    check(o_burst8 === exp8, "read burst length");
    idle(1);
  endtask
  task automatic give_verdict();
    $display("Checks %0d, errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    error_cnt = 0;
    total_checks = 0;
    i_rst = 1'b1;
    i_req_valid = 1'b0;
    i_req_cmd = CMD_NOP;
    i_req_bank = 3'h0;
    i_req_addr = 13'h0000;
    i_wr_data = '0;
    i_wr_mask_n = '1;
    shadow = '0;
    idle(3);
    i_rst = 1'b0;
    idle(8);
    check(o_bank_open === 8'h00 && o_dbi_en === 1'b0, "state after reset");
    send(CMD_ACT, 3'h1, 13'h0000);
    idle(12);
    check(o_bank_open[1] === 1'b1, "bank not opened");
    wr(13'h0000, {8{16'hA5C3}} ^ 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210, 16'hFFFF, 8, 0);
    rd(13'h0000, 8, 1'b1);
    wr(13'h0000, {8{16'h3CF0}}, 16'h5AC3, 8, 0);
    rd(13'h0000, 8, 1'b1);
    send(CMD_MRS, MR0_SEL, 13'h002E);
    wr(13'h0000, {8{16'h1E2D}}, 16'hFFFF, 4, 0);
    rd(13'h0000, 4, 1'b0);
    send(CMD_MRS, MR0_SEL, 13'h002D);
    wr(13'h1000, {8{16'h9B6A}}, 16'hFFFF, 8, 0);
    rd(13'h0000, 4, 1'b0);
    rd(13'h1000, 8, 1'b1);
    send(CMD_MRS, MR2_SEL, 13'h0019);
    wr(13'h1000, {8{16'h7E81}}, 16'hFFFF, 8, 0);
    rd(13'h1000, 8, 1'b1);
    send(CMD_MRS, MR1_SEL, 13'h0009);
    rd(13'h1000, 8, 1'b1);
    send(CMD_PRE, 3'h1, 13'h0000);
    idle(12);
    check(o_bank_open[1] === 1'b0, "bank not closed");
    send(CMD_ACT, 3'h1, 13'h0000);
    rd(13'h1400, 8, 1'b1);
    idle(12);
    check(o_bank_open[1] === 1'b0, "auto precharge missing");
    send(CMD_ACT, 3'h1, 13'h0000);
    rd(13'h1000, 8, 1'b1);
    check(o_bank_open[1] === 1'b1, "bank closed early");
    send(CMD_MRS, MR5_SEL, 13'h0800);
    idle(12);
    check(o_dbi_en === 1'b1, "inversion not enabled");
    wr(13'h1000, {8{16'hC35A}}, 16'h00FF, 8, 1);
    rd(13'h1000, 8, 1'b1);
    give_verdict();
  end
endmodule
